/* core/dsm_pkg.sv */
// Constants and carrier types for the timeslot monitor block
`default_nettype none
package dsm_pkg;
    localparam logic [7:0] TX_SLOT_CTRL_ADDR = 8'h19;
    localparam logic [7:0] TX_SNOOP_ADDR = 8'h1A;
    localparam logic [7:0] RX_SLOT_CTRL_ADDR = 8'h1E;
    localparam logic [7:0] RX_SNOOP_ADDR = 8'h1F;
    localparam logic [7:0] SIG_CTRL_ADDR = 8'h07;
    localparam logic [7:0] RX_SIG_BASE_ADDR = 8'h60;
    localparam logic [7:0] TX_SIG_BASE_ADDR = 8'h70;
    localparam int SIG_REG_COUNT = 12;
    localparam int SLOT_SEL_MSB = 4;
    localparam int FORCE_ONES_BIT = 5;
    localparam int TX_INSERT_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SNOOP_RESET = 8'h00;
    localparam int FRAME_DATA_BITS = 192;
    localparam int SLOT_BITS = 8;

    typedef struct packed {
        logic data;
        logic valid;
        logic frame_sync;
        logic robbed_pos;
    } dsm_stream_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dsm_host_req_t;
endpackage
`default_nettype wire

/* core/dsm_slot_capture.sv */
// Captures one selected timeslot of a framed serial stream into a byte
`default_nettype none
module dsm_slot_capture
    import dsm_pkg::*;
#(
    parameter int CHANNELS = 24
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Stream and selection
    input wire dsm_stream_t stream_in,
    input wire logic [4:0] slot_sel_in,
    // Captured byte
    output logic [7:0] snoop_out
);
    if (CHANNELS * SLOT_BITS != FRAME_DATA_BITS || CHANNELS > 31) begin : g_bad_channels
        $error("dsm_slot_capture: unsupported channel count");
    end

    logic [7:0] bit_pos;
    logic [6:0] shift;
    wire in_frame = bit_pos < 8'(FRAME_DATA_BITS);
    wire [4:0] cur_chan = 5'(bit_pos[7:3] + 5'h01);
    wire selected = in_frame && (cur_chan == slot_sel_in);
    wire take_bit = stream_in.valid && !stream_in.frame_sync && selected;
    wire last_bit = take_bit && (bit_pos[2:0] == 3'h7);
    // Frame sync marks the framing bit, so counting starts at the next bit
    wire [7:0] next_bit_pos = stream_in.frame_sync ? 8'h00 : 8'(bit_pos + 8'h01);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_pos <= 8'hFF;
        end else if (stream_in.valid && (stream_in.frame_sync || in_frame)) begin
            bit_pos <= next_bit_pos;
        end
    end

    // First bit on the wire lands in bit 7
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift <= 7'h00;
        end else if (take_bit) begin
            shift <= {shift[5:0], stream_in.data};
        end
    end

    // Whole byte only, so the host never sees a half-filled slot
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            snoop_out <= SNOOP_RESET;
        end else if (last_bit) begin
            snoop_out <= {shift, stream_in.data};
        end
    end

    snoop_last_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        last_bit |=> snoop_out[0] == $past(stream_in.data));
    snoop_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !$past(last_bit) |-> $stable(snoop_out));
    slot_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (slot_sel_in == 5'h00) |-> !take_bit);
    byte_done_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) last_bit);
endmodule
`default_nettype wire

/* core/dsm_monitor_top.sv */
// Timeslot monitor, robbed-bit control and signaling registers
// Summary of operation
// - The transmit monitor register at 1A holds the chosen outgoing slot, first bit in bit 7.
// - The receive monitor register holds the chosen incoming slot, first bit in bit 7.
// - Bits 4..0 of the receive slot control register pick the incoming channel monitored.
// - Register signaling access and pin signaling access work at the same time.
// - Robbed signaling bits are extracted on receive and can be inserted on transmit.
// - Twelve receive and twelve transmit signaling registers are provided.
// - With the force bit clear, robbed bits pass to the receive serial output unchanged.
// - With the force bit set, every robbed bit position on the receive output is one.
// - Bits 4..0 of the transmit slot control register pick the outgoing channel monitored.
`default_nettype none
module dsm_monitor_top
    import dsm_pkg::*;
#(
    parameter int CHANNELS = 24,
    parameter int SIG_REGS = SIG_REG_COUNT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Parallel control port
    input wire dsm_host_req_t host_in,
    output logic [7:0] rdata_out,
    // Transmit stream
    input wire dsm_stream_t tx_stream_in,
    input wire logic tx_sig_bit_in,
    output logic tx_serial_out,
    output logic [SIG_REGS*8-1:0] tx_sig_regs_out,
    // Receive stream and extracted signaling
    input wire dsm_stream_t rx_stream_in,
    input wire logic rx_sig_load_in,
    input wire logic [3:0] rx_sig_index_in,
    input wire logic [7:0] rx_sig_data_in,
    output logic rx_serial_out
);
    // Bank index is four bits wide, so the count is pinned
    if (SIG_REGS != SIG_REG_COUNT) begin : g_bad_sig_regs
        $error("dsm_monitor_top: signaling register count must be twelve");
    end

    logic [7:0] tx_slot_select_control;
    logic [7:0] rx_slot_select_control;
    logic [7:0] sig_ctrl;
    logic [7:0] rx_sig_regs [SIG_REGS];
    logic [7:0] tx_sig_regs [SIG_REGS];
    logic [7:0] tx_channel_snoop;
    logic [7:0] rx_channel_snoop;

    wire [4:0] tx_slot_select = tx_slot_select_control[SLOT_SEL_MSB:0];
    wire [4:0] rx_slot_select = rx_slot_select_control[SLOT_SEL_MSB:0];
    wire rx_robbed_force_ones = sig_ctrl[FORCE_ONES_BIT];
    wire tx_insert_en = sig_ctrl[TX_INSERT_BIT];

    // Monitors for both directions run side by side
    dsm_slot_capture #(.CHANNELS(CHANNELS)) u_tx_cap (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .stream_in(tx_stream_in),
        .slot_sel_in(tx_slot_select),
        .snoop_out(tx_channel_snoop)
    );

    dsm_slot_capture #(.CHANNELS(CHANNELS)) u_rx_cap (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .stream_in(rx_stream_in),
        .slot_sel_in(rx_slot_select),
        .snoop_out(rx_channel_snoop)
    );

    // Address decode
    wire wr_tx_ctrl = host_in.wr && (host_in.addr == TX_SLOT_CTRL_ADDR);
    wire wr_rx_ctrl = host_in.wr && (host_in.addr == RX_SLOT_CTRL_ADDR);
    wire wr_sig_ctrl = host_in.wr && (host_in.addr == SIG_CTRL_ADDR);
    wire [7:0] rx_sig_off = 8'(host_in.addr - RX_SIG_BASE_ADDR);
    wire [7:0] tx_sig_off = 8'(host_in.addr - TX_SIG_BASE_ADDR);
    wire hit_rx_sig = (host_in.addr >= RX_SIG_BASE_ADDR) && (rx_sig_off < 8'(SIG_REGS));
    wire hit_tx_sig = (host_in.addr >= TX_SIG_BASE_ADDR) && (tx_sig_off < 8'(SIG_REGS));

    logic [7:0] read_mux;
    always_comb begin
        read_mux = 8'h00;
        if (host_in.addr == TX_SLOT_CTRL_ADDR) begin
            read_mux = tx_slot_select_control;
        end else if (host_in.addr == TX_SNOOP_ADDR) begin
            read_mux = tx_channel_snoop;
        end else if (host_in.addr == RX_SLOT_CTRL_ADDR) begin
            read_mux = rx_slot_select_control;
        end else if (host_in.addr == RX_SNOOP_ADDR) begin
            read_mux = rx_channel_snoop;
        end else if (host_in.addr == SIG_CTRL_ADDR) begin
            read_mux = sig_ctrl;
        end else if (hit_rx_sig) begin
            read_mux = rx_sig_regs[rx_sig_off[3:0]];
        end else if (hit_tx_sig) begin
            read_mux = tx_sig_regs[tx_sig_off[3:0]];
        end
    end

    // Read data is held until the next read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (host_in.rd) begin
            rdata_out <= read_mux;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_slot_select_control <= CTRL_RESET;
            rx_slot_select_control <= CTRL_RESET;
            sig_ctrl <= CTRL_RESET;
        end else begin
            if (wr_tx_ctrl) begin
                tx_slot_select_control <= host_in.wdata;
            end
            if (wr_rx_ctrl) begin
                rx_slot_select_control <= host_in.wdata;
            end
            if (wr_sig_ctrl) begin
                sig_ctrl <= host_in.wdata;
            end
        end
    end

    // Signaling register banks; hardware loads the receive side, host the transmit side
    genvar gi;
    generate
        for (gi = 0; gi < SIG_REGS; gi++) begin : g_sig
            wire rx_load = rx_sig_load_in && (rx_sig_index_in == 4'(gi));
            wire tx_wr = host_in.wr && hit_tx_sig && (tx_sig_off[3:0] == 4'(gi));
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    rx_sig_regs[gi] <= 8'h00;
                    tx_sig_regs[gi] <= 8'h00;
                    tx_sig_regs_out[gi*8 +: 8] <= 8'h00;
                end else begin
                    if (rx_load) begin
                        rx_sig_regs[gi] <= rx_sig_data_in;
                    end
                    if (tx_wr) begin
                        tx_sig_regs[gi] <= host_in.wdata;
                        tx_sig_regs_out[gi*8 +: 8] <= host_in.wdata;
                    end
                end
            end
        end
    endgenerate

    // Robbed positions on the receive and transmit outputs; the pin path stays live beside the registers
    wire rx_force = rx_stream_in.robbed_pos && rx_robbed_force_ones;
    wire next_rx_serial = rx_force ? 1'b1 : rx_stream_in.data;
    wire tx_insert = tx_stream_in.robbed_pos && tx_insert_en;
    wire next_tx_serial = tx_insert ? tx_sig_bit_in : tx_stream_in.data;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_serial_out <= 1'b0;
            tx_serial_out <= 1'b0;
        end else begin
            if (rx_stream_in.valid) begin
                rx_serial_out <= next_rx_serial;
            end
            if (tx_stream_in.valid) begin
                tx_serial_out <= next_tx_serial;
            end
        end
    end

    force_ones_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_stream_in.valid && rx_stream_in.robbed_pos && rx_robbed_force_ones
        |=> rx_serial_out);
    robbed_pass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_stream_in.valid && !rx_robbed_force_ones
        |=> rx_serial_out == $past(rx_stream_in.data));
    tx_insert_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tx_stream_in.valid && tx_stream_in.robbed_pos && tx_insert_en
        |=> tx_serial_out == $past(tx_sig_bit_in));
    rx_snoop_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        host_in.rd && host_in.addr == RX_SNOOP_ADDR |=> rdata_out == $past(rx_channel_snoop));
    tx_snoop_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        host_in.rd && host_in.addr == TX_SNOOP_ADDR |=> rdata_out == $past(tx_channel_snoop));
    rx_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_rx_ctrl |=> rx_slot_select == $past(host_in.wdata[4:0]));
    tx_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_tx_ctrl |=> tx_slot_select == $past(host_in.wdata[4:0]));
    sig_bank_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_sig_load_in && rx_sig_index_in < 4'(SIG_REGS)
        |=> rx_sig_regs[$past(rx_sig_index_in)] == $past(rx_sig_data_in));

    // Untouched bits pass straight through, and an idle cycle holds the line
    tx_pass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tx_stream_in.valid && !tx_insert |=> tx_serial_out == $past(tx_stream_in.data));
    tx_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !tx_stream_in.valid |=> $stable(tx_serial_out));
    rx_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rx_stream_in.valid |=> $stable(rx_serial_out));
    // Read data holds between reads, so a slow host never sees it move
    rdata_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !host_in.rd |=> $stable(rdata_out));
    rx_ctrl_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_rx_ctrl |=> $stable(rx_slot_select_control));
    tx_ctrl_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_tx_ctrl |=> $stable(tx_slot_select_control));
    tx_sig_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        host_in.wr && hit_tx_sig
        |=> tx_sig_regs_out[$past(tx_sig_off[3:0]) * 8 +: 8] == $past(host_in.wdata));
    rx_sig_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        host_in.rd && hit_rx_sig |=> rdata_out == $past(rx_sig_regs[rx_sig_off[3:0]]));
    tx_sig_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        host_in.rd && hit_tx_sig |=> rdata_out == $past(tx_sig_regs[tx_sig_off[3:0]]));
    force_used_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) rx_force);
    insert_used_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) tx_insert);
    sig_load_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) rx_sig_load_in);
endmodule
`default_nettype wire

/* sim/dsm_host_model.sv */
// Host processor model on the parallel control port
`default_nettype none
module dsm_host_model
    import dsm_pkg::*;
#(
    parameter bit HW_SIG = 1'b0
) (
    // Clock and read data
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // Request to the block
    output var dsm_host_req_t host_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_out = '0;
    // Address is scrambled after release so stale decode cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == RX_SLOT_CTRL_ADDR) v[6:5] = 2'b00;
        if (a == SIG_CTRL_ADDR && HW_SIG) v[FORCE_ONES_BIT] = 1'b0;
        @(posedge clk_in);
        host_out <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        host_out <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        host_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        host_out <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* sim/ds0_channel_monitor_tb.sv */
// Self-checking bench for the timeslot monitor block
`default_nettype none
module ds0_channel_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dsm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    dsm_host_req_t host_in;
    logic [7:0] rdata_out;
    logic [7:0] rd_val;
    dsm_stream_t tx_stream_in = '0;
    dsm_stream_t rx_stream_in = '0;
    logic tx_sig_bit_in = 1'b0;
    logic rx_sig_load_in = 1'b0;
    logic [3:0] rx_sig_index_in = 4'h0;
    logic [7:0] rx_sig_data_in = 8'h00;
    logic tx_serial_out;
    logic rx_serial_out;
    logic [SIG_REG_COUNT*8-1:0] tx_sig_regs_out;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk_in = ~clk_in;
    dsm_monitor_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_in(host_in),
        .rdata_out(rdata_out), .tx_stream_in(tx_stream_in), .tx_sig_bit_in(tx_sig_bit_in),
        .tx_serial_out(tx_serial_out), .tx_sig_regs_out(tx_sig_regs_out),
        .rx_stream_in(rx_stream_in), .rx_sig_load_in(rx_sig_load_in),
        .rx_sig_index_in(rx_sig_index_in), .rx_sig_data_in(rx_sig_data_in),
        .rx_serial_out(rx_serial_out));
    dsm_host_model host (.clk_in(clk_in), .rdata_in(rdata_out), .host_out(host_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rd_val);
        chk(rd_val, exp);
    endtask
    // Distinct byte per channel, lsb alternates so robbed bits vary
    function automatic logic [7:0] chan_byte(input int n, input logic [7:0] salt);
        return 8'(n * 11) ^ salt;
    endfunction
    // Sync bit then 24 channels, serial outputs checked one cycle later
    task automatic send_frame(input logic [7:0] salt, input logic frc, input logic ins);
        logic [7:0] tb;
        logic [7:0] rb;
        logic texp;
        logic rexp;
        int k;
        texp = 1'b0;
        rexp = 1'b0;
        for (int i = 0; i <= 193; i++) begin
            @(posedge clk_in);
            k = (i - 1) % 8;
            tb = chan_byte((i - 1) / 8 + 1, ~salt);
            rb = chan_byte((i - 1) / 8 + 1, salt);
            if (i == 0) begin
                tx_stream_in <= '{data: 1'b0, valid: 1'b1, frame_sync: 1'b1, robbed_pos: 1'b0};
                rx_stream_in <= '{data: 1'b0, valid: 1'b1, frame_sync: 1'b1, robbed_pos: 1'b0};
            end else if (i <= 192) begin
                tx_stream_in <= '{data: tb[7-k], valid: 1'b1, frame_sync: 1'b0, robbed_pos: k == 7};
                rx_stream_in <= '{data: rb[7-k], valid: 1'b1, frame_sync: 1'b0, robbed_pos: k == 7};
            end else begin
                tx_stream_in <= '0;
                rx_stream_in <= '0;
            end
            #1;
            if (i > 0) begin
                chk({7'h00, tx_serial_out}, {7'h00, texp});
                chk({7'h00, rx_serial_out}, {7'h00, rexp});
            end
            if (i > 0 && i <= 192) begin
                texp = (ins && k == 7) ? tx_sig_bit_in : tb[7-k];
                rexp = (frc && k == 7) ? 1'b1 : rb[7-k];
            end
        end
    endtask
    task automatic test_reset();
        rd_chk(TX_SNOOP_ADDR, SNOOP_RESET);
        rd_chk(RX_SNOOP_ADDR, SNOOP_RESET);
        rd_chk(RX_SLOT_CTRL_ADDR, CTRL_RESET);
        rd_chk(TX_SLOT_CTRL_ADDR, CTRL_RESET);
        rd_chk(8'h55, 8'h00);
        $display("test reset done");
    endtask
    // Stored upper bits must not disturb the channel choice
    task automatic test_select();
        host.wr(RX_SLOT_CTRL_ADDR, 8'hEF);
        host.wr(TX_SLOT_CTRL_ADDR, 8'h06);
        host.wr(RX_SNOOP_ADDR, 8'hFF);
        rd_chk(RX_SNOOP_ADDR, SNOOP_RESET);
        send_frame(8'h00, 1'b0, 1'b0);
        rd_chk(RX_SNOOP_ADDR, chan_byte(15, 8'h00));
        rd_chk(TX_SNOOP_ADDR, chan_byte(6, 8'hFF));
        rd_chk(RX_SLOT_CTRL_ADDR, 8'h8F);
        host.wr(RX_SLOT_CTRL_ADDR, 8'h18);
        host.wr(TX_SLOT_CTRL_ADDR, 8'h01);
        send_frame(8'h40, 1'b0, 1'b0);
        rd_chk(RX_SNOOP_ADDR, chan_byte(24, 8'h40));
        rd_chk(TX_SNOOP_ADDR, chan_byte(1, 8'hBF));
        $display("test select done");
    endtask
    task automatic test_force();
        host.wr(SIG_CTRL_ADDR, 8'h30);
        host.wr(RX_SLOT_CTRL_ADDR, 8'h19);
        tx_sig_bit_in <= 1'b1;
        send_frame(8'h00, 1'b1, 1'b1);
        // Channel 25 does not exist, so the old receive byte must survive
        rd_chk(RX_SNOOP_ADDR, chan_byte(24, 8'h40));
        rd_chk(TX_SNOOP_ADDR, chan_byte(1, 8'hFF));
        @(posedge clk_in);
        tx_sig_bit_in <= 1'b0;
        send_frame(8'h5A, 1'b1, 1'b1);
        $display("test force done");
    endtask
    task automatic test_sig();
        for (int i = 0; i < SIG_REG_COUNT; i++) begin
            host.wr(TX_SIG_BASE_ADDR + 8'(i), 8'hC0 + 8'(i));
            #1;
            chk(tx_sig_regs_out[8*i+:8], 8'hC0 + 8'(i));
            @(posedge clk_in);
            rx_sig_load_in <= 1'b1;
            rx_sig_index_in <= 4'(i);
            rx_sig_data_in <= 8'h30 + 8'(i);
            @(posedge clk_in);
            rx_sig_load_in <= 1'b0;
            host.wr(RX_SIG_BASE_ADDR + 8'(i), 8'hFF);
            rd_chk(RX_SIG_BASE_ADDR + 8'(i), 8'h30 + 8'(i));
            rd_chk(TX_SIG_BASE_ADDR + 8'(i), 8'hC0 + 8'(i));
        end
        $display("test signaling done");
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // About 950 cycles expected, generous margin
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        test_reset();
        test_select();
        test_force();
        test_sig();
        print_verdict();
    end
endmodule
`default_nettype wire
